// file: bench/fbsp_mac_model.sv
// fbsp_mac_model: medium access layer stand-in, hands telegrams to the slave.
// assumes: one clock; caller enters send just after a rising edge.
`timescale 1ns/100ps

module fbsp_mac_model (
  input  wire logic                 clk,
  input  wire fbsp_pkg::fbsp_resp_t mediumResp,
  output fbsp_pkg::fbsp_tg_t        tg
);
  import fbsp_pkg::*;
  initial tg = '0;
  // one-cycle event; between events the fields carry scrambled leftovers
  task automatic send(input fbsp_tg_t t, output fbsp_resp_t r);
    fbsp_tg_t idle;
    t.b13 = t.b13 & 8'hc4; // no user data in the reserved bits of byte 13; bits 7, 6 and 2 pass
    idle = ~t;
    idle.kind = FBSP_TG_NONE;
    tg <= t;
    @(posedge clk);
    tg <= idle;
    @(posedge clk);
    r = mediumResp;
  endtask
endmodule

// file: bench/tb.sv
// tb: register and telegram sequences against the slave unit.
// assumes: fbsp_slave and fbsp_mac_model compiled before this file.
`timescale 1ns/100ps

module tb;
  import fbsp_pkg::*;
  logic clk = 0, rst = 1, wdExpired = 0;
  fbsp_tg_t tg;
  fbsp_mode_t slaveMode;
  fbsp_bufs_t bufMap;
  fbsp_resp_t mediumResp, r;
  logic [7:0] stationAddr, respDelay, s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int errors = 0, total_checks = 0;

  always #20 clk = ~clk;

  fbsp_slave DUT (.clk(clk), .rst(rst), .tg(tg), .wdExpired(wdExpired), .slaveMode(slaveMode),
    .bufMap(bufMap), .mediumResp(mediumResp), .stationAddr(stationAddr), .respDelay(respDelay),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  fbsp_mac_model MAC (.clk(clk), .mediumResp(mediumResp), .tg(tg));

  // -----------------------------------------------------------------
  // bus and compare tasks
  // -----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    br = s_axi_bresp;
    s_axi_bready <= 0;
    // one idle edge so a following call never re-drives the same step
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // data-exchange kinds go to the restricted service points
  function automatic fbsp_tg_t mk(fbsp_tgkind_t k, logic [7:0] len, logic [7:0] b6,
                                  logic [7:0] b9);
    fbsp_tg_t t;
    t = '0;
    t.kind = k;
    t.restricted = (k == FBSP_TG_OUT) || (k == FBSP_TG_CLEAR) || (k == FBSP_TG_INSNT);
    t.sizeOk = 1;
    t.cfgOk = 1;
    t.netLen = len;
    t.srcAddr = 8'h02;
    t.b6 = b6;
    t.b9 = b9;
    return t;
  endfunction

  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    print_verdict();
  end

  // -----------------------------------------------------------------
  // sequences
  // -----------------------------------------------------------------
  initial begin
    fbsp_tg_t t;
    repeat (16) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    chk(respDelay, 8'h0b);
    chk(bufMap.outC, 2'h3);
    MAC.send(mk(FBSP_TG_SSA, 8'h04, 8'h05, 8'h00), r);
    chk(r.valid, 1'b0);
    wr(8'h00, 32'h1);
    wr(8'h1c, 32'h1);
    chk(slaveMode, FBSP_WPRM);
    rd(8'h08);
    chk(d, 32'h3);
    t = mk(FBSP_TG_SSA, 8'h04, 8'h05, 8'h00);
    t.sizeOk = 0;
    MAC.send(t, r);
    chk(r.code, FBSP_RSP_NORES);
    wr(8'h00, 32'h3);
    MAC.send(mk(FBSP_TG_SSA, 8'h04, 8'h05, 8'h00), r);
    chk(r.code, FBSP_RSP_NOSRV);
    wr(8'h00, 32'h1);
    MAC.send(mk(FBSP_TG_SSA, 8'h04, 8'h05, 8'h00), r);
    chk(r.code, FBSP_RSP_SACK);
    chk(stationAddr, 8'h05);
    chk(bufMap.ssaSel, 1'b1);
    rd(8'h08);
    chk(d, 32'h0);
    MAC.send(mk(FBSP_TG_SSA, 8'h04, 8'h05, 8'h00), r);
    chk(r.code, FBSP_RSP_IGN);
    wr(8'h1c, 32'h1);
    MAC.send(mk(FBSP_TG_SSA, 8'h04, 8'h7e, 8'h00), r);
    chk(r.code, FBSP_RSP_SACK);
    rd(8'h08);
    chk(d, 32'h3);
    MAC.send(mk(FBSP_TG_PRM, 8'h06, 8'h00, 8'h05), r);
    chk(slaveMode, FBSP_WPRM);
    MAC.send(mk(FBSP_TG_PRM, 8'h07, 8'h00, 8'h05), r);
    chk(slaveMode, FBSP_WCFG);
    chk(respDelay, 8'h0b);
    rd(8'h0c);
    chk(d, 32'h3);
    MAC.send(mk(FBSP_TG_PRM, 8'h07, 8'ha8, 8'h14), r);
    chk(slaveMode, FBSP_WPRM);
    rd(8'h04);
    chk(d, 32'h0000_01c4);
    MAC.send(mk(FBSP_TG_PRM, 8'h07, 8'h88, 8'h14), r);
    MAC.send(mk(FBSP_TG_PRM, 8'h07, 8'h88, 8'h14), r);
    chk(respDelay, 8'h14);
    rd(8'h0c);
    chk(d, 32'h1);
    MAC.send(mk(FBSP_TG_OUT, 8'h04, 8'h00, 8'h00), r);
    chk(r.code, FBSP_RSP_IGN);
    MAC.send(mk(FBSP_TG_CFG, 8'h04, 8'h00, 8'h00), r);
    MAC.send(mk(FBSP_TG_OUT, 8'h04, 8'h00, 8'h00), r);
    chk(r.code, FBSP_RSP_DATA);
    chk(bufMap.outD, 2'h2);
    MAC.send(mk(FBSP_TG_CLEAR, 8'h00, 8'h00, 8'h00), r);
    chk(bufMap.outU, 2'h3);
    wr(8'h1c, 32'h2);
    MAC.send(mk(FBSP_TG_INSNT, 8'h00, 8'h00, 8'h00), r);
    chk(bufMap.inD, 2'h1);
    wr(8'h1c, 32'h1c);
    chk(bufMap.diagSel, 1'b1);
    chk(bufMap.cfgRbSel, 1'b1);
    chk(bufMap.outU, 2'h0);
    wdExpired <= 1;
    @(posedge clk);
    wdExpired <= 0;
    @(posedge clk);
    chk(slaveMode == FBSP_DEX, 1'b0);
    chk(bufMap.outU, 2'h1);
    rd(8'h40);
    chk(rr, 2'b10);
    wr(8'h40, 32'h0);
    chk(br, 2'b10);
    print_verdict();
  end
endmodule

// file: core/fbsp_consts.svh
// fbsp_consts.svh: register offsets, field positions, reset values and
// protocol figures of the fieldbus slave parameter/buffer unit.
// assumes: included by bare name from the slave design file; the package does not include it.
`ifndef FBSP_CONSTS_SVH
`define FBSP_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FBSP_OFS_CTRL      8'h00
`define FBSP_OFS_STATUS    8'h04
`define FBSP_OFS_SSA_ACK   8'h08
`define FBSP_OFS_PRM_ACK   8'h0c
`define FBSP_OFS_PARAM     8'h10
`define FBSP_OFS_IDENT     8'h14
`define FBSP_OFS_BUFS      8'h18
`define FBSP_OFS_CMD       8'h1c

// ----------------------------------------------------------------
// control bits, command bits
// ----------------------------------------------------------------
`define FBSP_CTL_EN        0
`define FBSP_CTL_SSA_DIS   1
`define FBSP_CTL_SYNC_SUP  2
`define FBSP_CTL_FRZ_SUP   3
`define FBSP_CMD_START     0
`define FBSP_CMD_IN_NEXT   1
`define FBSP_CMD_OUT_FETCH 2
`define FBSP_CMD_DIAG_SWAP 3
`define FBSP_CMD_CFGRB_SWP 4

// ----------------------------------------------------------------
// acknowledge codes
// ----------------------------------------------------------------
`define FBSP_ACK_DONE      2'b00
`define FBSP_ACK_CLASH     2'b01
`define FBSP_ACK_NOT_ALLOW 2'b11

// ----------------------------------------------------------------
// telegram field positions and limits
// ----------------------------------------------------------------
`define FBSP_B6_LOCK       7
`define FBSP_B6_UNLOCK     6
`define FBSP_B6_SYNC       5
`define FBSP_B6_FREEZE     4
`define FBSP_B6_WDON       3
`define FBSP_B13_EXT_EN    7
`define FBSP_B13_FAILSAFE  6
`define FBSP_B13_WDBASE    2
`define FBSP_MIN_DELAY     8'd11
`define FBSP_DELAY_FLOOR   8'd10
`define FBSP_DELAY_KEEP    8'h00
`define FBSP_MAX_ADDR      8'd125
`define FBSP_NO_CHANGE     8'hff
`define FBSP_SSA_MINLEN    8'd4
`define FBSP_PRM_MINLEN    8'd7
`define FBSP_PRM_EXTLEN    8'd7
`define FBSP_EXT_DEFAULT   1'b0

// ----------------------------------------------------------------
// buffer indices after reset, register bus response codes
// ----------------------------------------------------------------
`define FBSP_RST_OUT_U     2'h1
`define FBSP_RST_OUT_N     2'h2
`define FBSP_RST_OUT_C     2'h3
`define FBSP_RST_IN_U      2'h1
`define FBSP_RST_IN_N      2'h2
`define FBSP_AXI_OKAY      2'b00
`define FBSP_AXI_SLVERR    2'b10

`endif

// file: core/fbsp_pkg.sv
// fbsp_pkg: types of the fieldbus slave parameter/buffer unit.
// assumes: nothing; it uses no macro of the constants header.
package fbsp_pkg;
  typedef enum logic [1:0] {
    FBSP_OFF  = 2'b00,
    FBSP_WPRM = 2'b01,
    FBSP_WCFG = 2'b10,
    FBSP_DEX  = 2'b11
  } fbsp_mode_t;

  typedef enum logic [2:0] {
    FBSP_TG_NONE  = 3'b000,
    FBSP_TG_OUT   = 3'b001,
    FBSP_TG_CLEAR = 3'b010,
    FBSP_TG_INSNT = 3'b011,
    FBSP_TG_SSA   = 3'b100,
    FBSP_TG_PRM   = 3'b101,
    FBSP_TG_CFG   = 3'b110
  } fbsp_tgkind_t;

  typedef enum logic [2:0] {
    FBSP_RSP_NONE  = 3'b000,
    FBSP_RSP_SACK  = 3'b001,
    FBSP_RSP_NOSRV = 3'b010,
    FBSP_RSP_NORES = 3'b011,
    FBSP_RSP_DATA  = 3'b100,
    FBSP_RSP_IGN   = 3'b101
  } fbsp_rsp_t;

  typedef struct packed {
    fbsp_tgkind_t kind;
    logic         restricted;
    logic         sizeOk;
    logic         cfgOk;
    logic [7:0]   netLen;
    logic [7:0]   srcAddr;
    logic [7:0]   b6, b7, b8, b9, b10, b11, b12, b13;
  } fbsp_tg_t;

  typedef struct packed {
    logic       valid;
    fbsp_rsp_t  code;
  } fbsp_resp_t;

  typedef struct packed {
    logic [1:0] outD, outU, outN, outC;
    logic       outNextFull;
    logic [1:0] inD, inU, inN;
    logic       inNextFull;
    logic       diagSel, cfgRbSel, ssaSel, prmSel, cfgSel;
  } fbsp_bufs_t;
endpackage

// file: core/fbsp_slave.sv
// fbsp_slave: fieldbus slave parameter and exchange-buffer manager.
// assumes: medium access layer presents each telegram as a one-cycle
// event with decoded fields; software on AXI4-Lite; one 25 MHz clock.
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps
`include "fbsp_consts.svh"

module fbsp_slave (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire fbsp_pkg::fbsp_tg_t    tg,
  input  wire logic                  wdExpired,
  output fbsp_pkg::fbsp_mode_t       slaveMode,
  output fbsp_pkg::fbsp_bufs_t       bufMap,
  output fbsp_pkg::fbsp_resp_t       mediumResp,
  output logic [7:0]                 stationAddr,
  output logic [7:0]                 respDelay,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);
  import fbsp_pkg::*;

  typedef struct packed {
    fbsp_mode_t  mode;
    logic        running;
    fbsp_bufs_t  bufs;
    fbsp_resp_t  resp;
    logic [7:0]  stationAddr, minDelay, respDelay;
    logic [7:0]  wdFact1, wdFact2, group, masterAddr;
    logic        wdOn, extEn, failSafe, wdBase;
    logic        notSupported, identFault, addrAdopted;
    logic [1:0]  ssaPend, prmPend, cfgPend;
    logic [3:0]  ctrl;
    logic [15:0] identExp;
    logic        awready, wready, awHeld, wHeld, bvalid;
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic [1:0]  bresp, rresp;
    logic        arready, rvalid;
    logic [31:0] rdata;
  } fbsp_state_t;

  fbsp_state_t s;
  fbsp_state_t n;
  logic [4:0]  cmd;

  // two pending indications before a read means one was overtaken
  function automatic logic [1:0] ackCode(input logic [1:0] pend);
    if (pend == 2'h0)
      ackCode = `FBSP_ACK_NOT_ALLOW;
    else if (pend == 2'h1)
      ackCode = `FBSP_ACK_DONE;
    else
      ackCode = `FBSP_ACK_CLASH;
  endfunction

  function automatic logic [1:0] bump(input logic [1:0] pend);
    bump = (pend == 2'h2) ? 2'h2 : pend + 2'h1;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    cmd = 5'h00;
    n.resp.valid = 1'b0;
    n.resp.code = FBSP_RSP_NONE;

    // register bus, write side
    if (s_axi_awvalid && s.awready) begin
      n.awHeld = 1'b1;
      n.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      n.wHeld = 1'b1;
      n.wData = s_axi_wdata;
      n.wStrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready)
      n.bvalid = 1'b0;
    if (s.awHeld && s.wHeld && !s.bvalid) begin
      n.awHeld = 1'b0;
      n.wHeld = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `FBSP_AXI_OKAY;
      case (s.awAddr)
        `FBSP_OFS_CTRL: begin
          if (s.wStrb[0])
            n.ctrl = s.wData[3:0];
        end
        `FBSP_OFS_IDENT: begin
          if (s.wStrb[0])
            n.identExp[7:0] = s.wData[7:0];
          if (s.wStrb[1])
            n.identExp[15:8] = s.wData[15:8];
        end
        `FBSP_OFS_CMD: begin
          if (s.wStrb[0])
            cmd = s.wData[4:0];
        end
        `FBSP_OFS_STATUS, `FBSP_OFS_SSA_ACK, `FBSP_OFS_PRM_ACK,
        `FBSP_OFS_PARAM, `FBSP_OFS_BUFS: begin
        end
        default: n.bresp = `FBSP_AXI_SLVERR;
      endcase
    end

    // register bus, read side; ack cells clear on read
    if (s.rvalid && s_axi_rready)
      n.rvalid = 1'b0;
    if (s_axi_arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp = `FBSP_AXI_OKAY;
      n.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        `FBSP_OFS_CTRL:   n.rdata[3:0] = s.ctrl;
        `FBSP_OFS_STATUS: n.rdata[15:0] = {s.cfgPend, s.prmPend, s.ssaPend,
                                           s.identFault, s.notSupported,
                                           s.addrAdopted, s.running, 2'b00,
                                           s.mode, 2'b00};
        `FBSP_OFS_SSA_ACK: begin
          n.rdata[1:0] = ackCode(s.ssaPend);
          n.ssaPend = 2'h0;
        end
        `FBSP_OFS_PRM_ACK: begin
          n.rdata[1:0] = ackCode(s.prmPend);
          n.prmPend = 2'h0;
        end
        `FBSP_OFS_PARAM:  n.rdata = {s.group, s.wdFact2, s.wdFact1, s.respDelay};
        `FBSP_OFS_IDENT:  n.rdata[15:0] = s.identExp;
        `FBSP_OFS_BUFS:   n.rdata[$bits(fbsp_bufs_t)-1:0] = s.bufs;
        default:          n.rresp = `FBSP_AXI_SLVERR;
      endcase
    end

    // ----------------------------------------------------------------
    // application commands
    // ----------------------------------------------------------------
    if (cmd[`FBSP_CMD_START] && s.ctrl[`FBSP_CTL_EN]) begin
      n.running = 1'b1;
      n.mode = FBSP_WPRM;
      n.ssaPend = 2'h0;
      n.addrAdopted = 1'b0;
    end
    if (cmd[`FBSP_CMD_IN_NEXT]) begin
      {n.bufs.inU, n.bufs.inN} = {n.bufs.inN, n.bufs.inU};
      n.bufs.inNextFull = 1'b1;
    end
    if (cmd[`FBSP_CMD_OUT_FETCH] && n.bufs.outNextFull) begin
      {n.bufs.outU, n.bufs.outN} = {n.bufs.outN, n.bufs.outU};
      n.bufs.outNextFull = 1'b0;
    end
    if (cmd[`FBSP_CMD_DIAG_SWAP])
      n.bufs.diagSel = !n.bufs.diagSel;
    if (cmd[`FBSP_CMD_CFGRB_SWP])
      n.bufs.cfgRbSel = !n.bufs.cfgRbSel;

    if (wdExpired && s.mode == FBSP_DEX && s.wdOn) begin
      n.mode = FBSP_WPRM;
      n.ssaPend = 2'h0;
      n.addrAdopted = 1'b0;
    end

    // ----------------------------------------------------------------
    // telegrams from the medium access layer
    // ----------------------------------------------------------------
    if (tg.kind != FBSP_TG_NONE && s.running) begin
      n.resp.valid = 1'b1;
      if (tg.restricted && s.mode != FBSP_DEX) begin
        n.resp.code = FBSP_RSP_IGN;
      end else begin
        case (tg.kind)
          FBSP_TG_OUT: begin
            {n.bufs.outD, n.bufs.outN} = {n.bufs.outN, n.bufs.outD};
            n.bufs.outNextFull = 1'b1;
            n.resp.code = FBSP_RSP_DATA;
          end
          FBSP_TG_CLEAR: begin
            {n.bufs.outU, n.bufs.outC} = {n.bufs.outC, n.bufs.outU};
            n.resp.code = FBSP_RSP_DATA;
          end
          FBSP_TG_INSNT: begin
            if (n.bufs.inNextFull) begin
              {n.bufs.inD, n.bufs.inN} = {n.bufs.inN, n.bufs.inD};
              n.bufs.inNextFull = 1'b0;
            end
            n.resp.code = FBSP_RSP_DATA;
          end
          FBSP_TG_SSA: begin
            if (s.ctrl[`FBSP_CTL_SSA_DIS]) begin
              n.resp.code = FBSP_RSP_NOSRV;
            end else if (!tg.sizeOk) begin
              n.resp.code = FBSP_RSP_NORES;
            end else if (s.addrAdopted) begin
              n.resp.code = FBSP_RSP_IGN;
            end else begin
              n.resp.code = FBSP_RSP_SACK;
              n.stationAddr = tg.b6;
              n.addrAdopted = 1'b1;
              if (s.mode != FBSP_WCFG && s.mode != FBSP_DEX &&
                  tg.netLen >= `FBSP_SSA_MINLEN && tg.b9 != `FBSP_NO_CHANGE &&
                  tg.b6 <= `FBSP_MAX_ADDR && {tg.b7, tg.b8} == s.identExp) begin
                n.bufs.ssaSel = !n.bufs.ssaSel;
                n.ssaPend = bump(n.ssaPend);
              end
            end
          end
          FBSP_TG_PRM: begin
            if (tg.netLen < `FBSP_PRM_MINLEN) begin
              n.resp.code = FBSP_RSP_IGN;
            end else begin
              n.resp.code = FBSP_RSP_SACK;
              n.identFault = 1'b0;
              n.notSupported = 1'b0;
              if ((tg.b6[`FBSP_B6_SYNC] && !s.ctrl[`FBSP_CTL_SYNC_SUP]) ||
                  (tg.b6[`FBSP_B6_FREEZE] && !s.ctrl[`FBSP_CTL_FRZ_SUP])) begin
                n.notSupported = 1'b1;
                n.mode = FBSP_WPRM;
              end else if ({tg.b10, tg.b11} != s.identExp) begin
                n.identFault = 1'b1;
                n.mode = FBSP_WPRM;
              end else if (tg.b6[`FBSP_B6_UNLOCK]) begin
                n.mode = FBSP_WPRM;
              end else if (!tg.b6[`FBSP_B6_LOCK]) begin
                n.mode = FBSP_WCFG;
                if (tg.b9 != `FBSP_DELAY_KEEP)
                  n.minDelay = tg.b9;
              end else begin
                n.mode = FBSP_WCFG;
                n.wdOn = tg.b6[`FBSP_B6_WDON];
                n.wdFact1 = tg.b7;
                n.wdFact2 = tg.b8;
                n.group = tg.b12;
                n.masterAddr = tg.srcAddr;
                if (tg.b9 > `FBSP_DELAY_FLOOR)
                  n.minDelay = tg.b9;
                // byte 13 taken only when netLen exceeds FBSP_PRM_EXTLEN; shorter telegrams load the defaults
                if (tg.netLen > `FBSP_PRM_EXTLEN) begin
                  n.extEn = tg.b13[`FBSP_B13_EXT_EN];
                  n.failSafe = tg.b13[`FBSP_B13_FAILSAFE];
                  n.wdBase = tg.b13[`FBSP_B13_WDBASE];
                end else begin
                  n.extEn = `FBSP_EXT_DEFAULT;
                  n.failSafe = `FBSP_EXT_DEFAULT;
                  n.wdBase = `FBSP_EXT_DEFAULT;
                end
                n.bufs.prmSel = !n.bufs.prmSel;
                n.prmPend = bump(n.prmPend);
              end
            end
          end
          FBSP_TG_CFG: begin
            if (tg.srcAddr == s.masterAddr && tg.cfgOk) begin
              n.resp.code = FBSP_RSP_SACK;
              n.bufs.cfgSel = !n.bufs.cfgSel;
              n.cfgPend = bump(n.cfgPend);
              if (s.mode == FBSP_WCFG)
                n.mode = FBSP_DEX;
            end else begin
              n.resp.code = FBSP_RSP_IGN;
            end
          end
          default: n.resp.code = FBSP_RSP_IGN;
        endcase
      end
    end

    // disabling wins over the mode any telegram sets in the same cycle
    if (!n.ctrl[`FBSP_CTL_EN]) begin
      n.running = 1'b0;
      n.mode = FBSP_OFF;
    end
    if (s.mode == FBSP_DEX && n.mode != FBSP_DEX)
      {n.bufs.outU, n.bufs.outC} = {n.bufs.outC, n.bufs.outU};

    n.respDelay = (n.minDelay < `FBSP_MIN_DELAY) ? `FBSP_MIN_DELAY : n.minDelay;
    n.awready = !n.awHeld;
    n.wready = !n.wHeld;
    n.arready = !n.rvalid;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.bufs.outU <= `FBSP_RST_OUT_U;
      s.bufs.outN <= `FBSP_RST_OUT_N;
      s.bufs.outC <= `FBSP_RST_OUT_C;
      s.bufs.inU <= `FBSP_RST_IN_U;
      s.bufs.inN <= `FBSP_RST_IN_N;
      s.respDelay <= `FBSP_MIN_DELAY;
    end else begin
      s <= n;
    end
  end

  assign slaveMode = s.mode;
  assign bufMap = s.bufs;
  assign mediumResp = s.resp;
  assign stationAddr = s.stationAddr;
  assign respDelay = s.respDelay;
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic tgLive;
  assign tgLive = tg.kind != FBSP_TG_NONE && s.running && s.ctrl[`FBSP_CTL_EN];

  property p_delay_floor;
    s.respDelay >= `FBSP_MIN_DELAY;
  endproperty
  a_delay_floor: assert property (p_delay_floor) else $error("delay below floor");

  property p_restricted;
    tgLive && tg.restricted && s.mode != FBSP_DEX |=> mediumResp.code == FBSP_RSP_IGN;
  endproperty
  a_restricted: assert property (p_restricted) else $error("restricted sap answered");

  property p_ssa_off;
    tgLive && tg.kind == FBSP_TG_SSA && !tg.restricted && s.ctrl[`FBSP_CTL_SSA_DIS]
      |=> mediumResp.valid && mediumResp.code == FBSP_RSP_NOSRV;
  endproperty
  a_ssa_off: assert property (p_ssa_off) else $error("disabled ssa not refused");

  property p_ssa_far;
    tgLive && tg.kind == FBSP_TG_SSA && !tg.restricted && !s.ctrl[`FBSP_CTL_SSA_DIS]
      && tg.b6 > `FBSP_MAX_ADDR |=> $stable(s.bufs.ssaSel);
  endproperty
  a_ssa_far: assert property (p_ssa_far) else $error("bad address indicated");

  property p_ack_idle;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `FBSP_OFS_SSA_ACK && s.ssaPend == 2'h0
      |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0003;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("idle ack code wrong");

  property p_prm_short;
    tgLive && tg.kind == FBSP_TG_PRM && !tg.restricted && tg.netLen < `FBSP_PRM_MINLEN
      && !wdExpired && !cmd[`FBSP_CMD_START] && n.ctrl[`FBSP_CTL_EN]
      && !(s_axi_arvalid && s_axi_arready && s_axi_araddr == `FBSP_OFS_PRM_ACK)
      |=> $stable(s.mode) && $stable(s.prmPend);
  endproperty
  a_prm_short: assert property (p_prm_short) else $error("short prm acted on");

  property p_sync_unsup;
    tgLive && tg.kind == FBSP_TG_PRM && !tg.restricted && tg.netLen >= `FBSP_PRM_MINLEN
      && tg.b6[`FBSP_B6_SYNC] && !s.ctrl[`FBSP_CTL_SYNC_SUP] && n.ctrl[`FBSP_CTL_EN]
      |=> s.notSupported && s.mode == FBSP_WPRM;
  endproperty
  a_sync_unsup: assert property (p_sync_unsup) else $error("sync not rejected");

  property p_out_swap;
    tgLive && tg.kind == FBSP_TG_OUT && s.mode == FBSP_DEX && n.mode == FBSP_DEX
      |=> s.bufs.outNextFull && s.bufs.outN == $past(s.bufs.outD);
  endproperty
  a_out_swap: assert property (p_out_swap) else $error("output buffer not moved");

  property p_fail_safe;
    s.mode == FBSP_DEX ##1 s.mode != FBSP_DEX |-> s.bufs.outU == $past(s.bufs.outC);
  endproperty
  a_fail_safe: assert property (p_fail_safe) else $error("fail-safe not handed");

  property p_start;
    cmd[`FBSP_CMD_START] && s.ctrl[`FBSP_CTL_EN] && n.ctrl[`FBSP_CTL_EN] && tg.kind == FBSP_TG_NONE
      |=> s.running && s.ssaPend == 2'h0 && !s.addrAdopted;
  endproperty
  a_start: assert property (p_start) else $error("start did not reset ssa");

  c_dex:    cover property (s.mode == FBSP_WCFG ##1 s.mode == FBSP_DEX);
  c_clash:  cover property (s.prmPend == 2'h2);
  c_ssaInd: cover property (s.ssaPend == 2'h0 ##1 s.ssaPend == 2'h1);
endmodule
